// file: logic/sadc_top.sv
/*
  Sequencer for an 8-bit successive-approximation converter: start flag,
  hardware trigger pin, channel routing, result latch, done request and
  interrupt, all reached over a simple register port.
  Assumes one 100 MHz clock, synchronous active-high reset, a register master
  that issues one-cycle strobes, and asynchronous trigger and comparator pins.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module sadc_top
  import sadc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire sadc_req_s         reg_req,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   irq,
  input  wire logic              external_trigger_pin,
  input  wire logic              cmp_pin,
  output logic      [DATA_W-1:0] dac_code,
  output logic      [NUM_CH-1:0] chan_sel
);

  ////////////////////////////////////////////////////////////////////////
  // state

  sadc_state_e       st_r;
  sadc_state_e       st_nxt;
  logic [DATA_W-1:0] mode_r;
  logic [DATA_W-1:0] result_r;
  logic [DATA_W-1:0] stat_r;
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] pmode_r;
  logic [DATA_W-1:0] edge_r;
  logic              trig_d_r;
  logic [1:0]        pins_s;
  logic              core_done;
  logic [DATA_W-1:0] core_result;
  logic [NUM_CH-1:0] chan_hot;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: trigger on bit 1, comparator on bit 0

  sadc_sync #(
    .W (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({external_trigger_pin, cmp_pin}),
    .q       (pins_s)
  );

  wire logic trig_s = pins_s[1];
  wire logic cmp_s  = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // register decode

  wire logic hit_start  = (reg_req.addr == OFF_START);
  wire logic hit_mode   = (reg_req.addr == OFF_MODE);
  wire logic hit_result = (reg_req.addr == OFF_RESULT);
  wire logic hit_stat   = (reg_req.addr == OFF_STAT);
  wire logic hit_mask   = (reg_req.addr == OFF_MASK);
  wire logic hit_pmode  = (reg_req.addr == OFF_PMODE);
  wire logic hit_edge   = (reg_req.addr == OFF_EDGE);

  wire logic wr_start = reg_req.wr && hit_start;
  wire logic wr_mode  = reg_req.wr && hit_mode;
  wire logic wr_mask  = reg_req.wr && hit_mask;
  wire logic wr_pmode = reg_req.wr && hit_pmode;
  wire logic wr_edge  = reg_req.wr && hit_edge;
  wire logic rd_stat  = reg_req.rd && hit_stat;

  ////////////////////////////////////////////////////////////////////////
  // start, stop and trigger qualification

  wire logic idle     = (st_r == SADC_IDLE);
  wire logic start_fl = (st_r == SADC_CONV);
  wire logic sw_set   = wr_start && reg_req.wdata[START_BIT];
  wire logic sw_stop  = wr_start && !reg_req.wdata[START_BIT];

  // trigger pin path gated by pin function and trigger enable
  wire logic trig_armed = pmode_r[PFUNC_BIT] && mode_r[TRIGGER_ENABLE_BIT_BIT];
  wire logic trig_rise  = trig_s && !trig_d_r;
  wire logic trig_fall  = !trig_s && trig_d_r;
  wire logic trig_edge  = edge_r[EDGE_BIT] ? trig_rise : trig_fall;
  wire logic trig_fire  = trig_armed && trig_edge;

  // a new conversion is only launched from idle
  wire logic core_start = idle && (sw_set || trig_fire);
  wire logic core_abort = start_fl && sw_stop;

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state: completion wins over a same-cycle stop

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SADC_IDLE: begin
        if (core_start) begin
          st_nxt = SADC_CONV;
        end
      end
      SADC_CONV: begin
        if (core_done) begin
          st_nxt = SADC_IDLE;
        end else if (sw_stop) begin
          st_nxt = SADC_IDLE;
        end
      end
      default: st_nxt = SADC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // status, mask and interrupt next values; a new event beats the read clear

  wire logic [DATA_W-1:0] done_evt = core_done ? (8'h01 << DONE_BIT) : 8'h00;
  wire logic [DATA_W-1:0] stat_nxt = (rd_stat ? 8'h00 : stat_r) | done_evt;
  wire logic [DATA_W-1:0] mask_nxt = wr_mask ? reg_req.wdata : mask_r;
  wire logic              irq_nxt  = |(stat_nxt & mask_nxt);

  ////////////////////////////////////////////////////////////////////////
  // read data selection; unmapped offsets read zero

  wire logic [DATA_W-1:0] start_view = {start_fl, START_RSV};
  wire logic [DATA_W-1:0] rd_val =
    hit_start  ? start_view :
    hit_mode   ? mode_r     :
    hit_result ? result_r   :
    hit_stat   ? stat_r     :
    hit_mask   ? mask_r     :
    hit_pmode  ? pmode_r    :
    hit_edge   ? edge_r     : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // channel routing: 01xx selects inputs 0..3, 10xx inputs 4..7

  wire logic [CHAN_W-1:0] chan_fld = mode_r[CHAN_LSB +: CHAN_W];

  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    assign chan_hot[i] = (chan_fld[3:2] == 2'(i / 4 + 1)) && (chan_fld[1:0] == 2'(i % 4));
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion engine

  sadc_sar_core u_core (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .start    (core_start),
    .abort    (core_abort),
    .cmp_hi   (cmp_s),
    .dac_code (dac_code),
    .done     (core_done),
    .result   (core_result)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer and result register

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r     <= SADC_IDLE;
      result_r <= REG_RST;
    end else begin
      st_r <= st_nxt;
      if (start_fl && core_done) begin
        result_r <= core_result;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r  <= REG_RST;
      pmode_r <= REG_RST;
      edge_r  <= REG_RST;
    end else begin
      if (wr_mode)  mode_r  <= reg_req.wdata;
      if (wr_pmode) pmode_r <= reg_req.wdata;
      if (wr_edge)  edge_r  <= reg_req.wdata;
    end
  end

  // status, mask, interrupt line
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_r <= REG_RST;
      mask_r <= REG_RST;
      irq    <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq    <= irq_nxt;
    end
  end

  // read data, trigger history, channel select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      trig_d_r  <= 1'b0;
      chan_sel  <= 8'h00;
    end else begin
      reg_rdata <= reg_req.rd ? rd_val : 8'h00;
      trig_d_r  <= trig_s;
      chan_sel  <= chan_hot;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // software start from idle raises the flag next cycle
  sw_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (idle && sw_set) |=> start_fl)
    else $error("software start did not raise the start flag");

  // the flag falls in the cycle after a completion
  flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start_fl && core_done) |=> !start_fl)
    else $error("start flag not cleared at completion");

  // completion sets the request flag
  done_req_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start_fl && core_done) |=> stat_r[DONE_BIT])
    else $error("done request not set at completion");

  // interrupt follows request and its enable
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (irq == (stat_r[DONE_BIT] && mask_r[DONE_BIT])))
    else $error("interrupt does not match request and enable");

  // result loads with the falling flag
  result_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start_fl && core_done) |=> (result_r == $past(core_result)) && idle)
    else $error("result not loaded at completion");

  // trigger edge ignored unless both gates are set
  trig_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (idle && trig_edge && !trig_armed && !sw_set) |=> !start_fl)
    else $error("trigger started conversion while disarmed");

  // armed trigger edge starts conversion
  trig_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    (idle && trig_fire) |=> start_fl)
    else $error("armed trigger edge did not start conversion");

  // 0101 routes input one alone
  chan_map_a: assert property (@(posedge ref_clk) disable iff (rst)
    (chan_fld == 4'h5) |=> (chan_sel == 8'h02))
    else $error("channel 0101 not routed to input one");

  // stop keeps result and request untouched
  stop_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start_fl && sw_stop && !core_done && !stat_r[DONE_BIT]) |=>
      !start_fl && $stable(result_r) && !stat_r[DONE_BIT])
    else $error("stopped conversion changed result or request");

  // reserved bits read as ones
  rsv_ones_a: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_req.rd && hit_start) |=> (reg_rdata[6:0] == 7'h7F))
    else $error("reserved start bits did not read as ones");

  // a repeated start during conversion does not relaunch the engine
  no_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start_fl && sw_set && !core_done) |-> !core_start ##1 start_fl)
    else $error("start during conversion restarted the engine");

  // flag stays up until completion or a stop
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start_fl && !core_done && !sw_stop) |=> start_fl)
    else $error("start flag fell during conversion");

  // the start register read shows the flag
  flag_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_req.rd && hit_start) |=> (reg_rdata[START_BIT] == $past(start_fl)))
    else $error("start register read does not show the flag");

  // the request flag only appears through a completion
  req_source_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!core_done && !stat_r[DONE_BIT]) |=> !stat_r[DONE_BIT])
    else $error("done request set without a completion");

  // a status read clears the request when no event competes
  req_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_stat && !core_done) |=> !stat_r[DONE_BIT])
    else $error("status read did not clear the done request");

  // a completion on the clearing read still sets the request
  set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_stat && core_done) |=> stat_r[DONE_BIT])
    else $error("read clear beat a same-cycle completion");

  // no interrupt while the enable bit stays clear
  irq_masked_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!mask_r[DONE_BIT] && !wr_mask) |=> !irq)
    else $error("interrupt raised with its enable clear");

  // the result register changes only at completion
  result_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(start_fl && core_done) |=> $stable(result_r))
    else $error("result register changed outside completion");

  // a rising trigger edge never starts a conversion while falling is selected
  edge_pol_a: assert property (@(posedge ref_clk) disable iff (rst)
    (idle && trig_armed && !edge_r[EDGE_BIT] && trig_rise && !sw_set) |=> !start_fl)
    else $error("rising trigger edge started conversion with falling selected");

  // unmapped channel codes route nothing
  chan_none_a: assert property (@(posedge ref_clk) disable iff (rst)
    (chan_fld[3] == chan_fld[2]) |=> (chan_sel == 8'h00))
    else $error("unmapped channel code routed an input");

  // at most one analog input is routed at a time
  chan_single_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> $onehot0(chan_sel))
    else $error("more than one analog input routed");

  // a stop parks the trial code and drops the flag
  stop_park_a: assert property (@(posedge ref_clk) disable iff (rst)
    (core_abort && !core_done) |=> (dac_code == 8'h00) && !start_fl)
    else $error("stop did not halt the engine");

endmodule : sadc_top

`default_nettype wire

// file: logic/sadc_pkg.sv
/*
  Shared constants and types for the 8-bit successive-approximation
  converter sequencer: register offsets, field positions, reset values,
  trial timing and the register request carrier.
  Assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
`default_nettype none

package sadc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_CH = 8;
  localparam int CHAN_W = 4;
  localparam int SET_W  = 3;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_START  = 3'h0; // start_control_reg
  localparam logic [ADDR_W-1:0] OFF_MODE   = 3'h1; // converter_mode_reg
  localparam logic [ADDR_W-1:0] OFF_RESULT = 3'h2; // conversion_result_reg
  localparam logic [ADDR_W-1:0] OFF_STAT   = 3'h3; // interrupt_request_reg_two
  localparam logic [ADDR_W-1:0] OFF_MASK   = 3'h4; // interrupt_enable_reg_two
  localparam logic [ADDR_W-1:0] OFF_PMODE  = 3'h5; // port_mode_reg_two
  localparam logic [ADDR_W-1:0] OFF_EDGE   = 3'h6; // edge_select_reg

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int START_BIT = 7; // conversion_start_flag
  localparam int CHAN_LSB  = 0; // channel_select_field
  localparam int TRIGGER_ENABLE_BIT_BIT  = 6; // trigger_enable_bit
  localparam int PFUNC_BIT = 4; // trigger_pin_function_select
  localparam int EDGE_BIT  = 4; // trigger_edge_select, 1 = rising
  localparam int DONE_BIT  = 0; // conversion_done_request / irq enable

  ////////////////////////////////////////////////////////////////////////
  // reset values and the first trial code
  localparam logic [6:0]        START_RSV  = 7'h7F;
  localparam logic [DATA_W-1:0] REG_RST    = 8'h00;
  localparam logic [DATA_W-1:0] TRIAL_TOP  = 8'h80;

  ////////////////////////////////////////////////////////////////////////
  // trial timing: comparator settle plus its two-flop synchroniser
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 40;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SETTLE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [0:0] {
    SADC_IDLE = 1'b0,
    SADC_CONV = 1'b1
  } sadc_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sadc_req_s;

endpackage : sadc_pkg

`default_nettype wire

// file: logic/sadc_sync.sv
/*
  Two-flop synchroniser, one stage pair per bit.
  Assumes inputs are asynchronous pins; only the second flop is read outside.
*/
`timescale 1ns/10ps
`default_nettype none

module sadc_sync
  import sadc_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // one synchroniser pair per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        meta_r[i] <= 1'b0;
        q[i]      <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end

endmodule : sadc_sync

`default_nettype wire

// file: logic/sadc_sar_core.sv
/*
  Successive-approximation engine: eight trials MSB first, each held for
  SETTLE_CYC cycles before the comparator is sampled.
  Assumes cmp_hi is already synchronised and is high when input >= dac_code.
*/
`timescale 1ns/10ps
`default_nettype none

module sadc_sar_core
  import sadc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              abort,
  input  wire logic              cmp_hi,
  output logic      [DATA_W-1:0] dac_code,
  output logic                   done,
  output logic      [DATA_W-1:0] result
);

  sadc_state_e       st_r;
  logic [DATA_W-1:0] mask_r;
  logic [SET_W-1:0]  wait_r;

  // trial decision
  wire logic              run      = (st_r == SADC_CONV);
  wire logic              decide   = run && (wait_r == SETTLE_LAST);
  wire logic [DATA_W-1:0] kept     = cmp_hi ? dac_code : (dac_code & ~mask_r);
  wire logic              last     = mask_r[0];

  // sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r     <= SADC_IDLE;
      mask_r   <= REG_RST;
      wait_r   <= '0;
      dac_code <= REG_RST;
      done     <= 1'b0;
      result   <= REG_RST;
    end else begin
      done <= 1'b0;
      case (st_r)
        SADC_IDLE: begin
          if (start) begin
            st_r     <= SADC_CONV;
            mask_r   <= TRIAL_TOP;
            dac_code <= TRIAL_TOP;
            wait_r   <= '0;
          end
        end
        SADC_CONV: begin
          if (abort) begin
            st_r     <= SADC_IDLE;
            dac_code <= REG_RST;
          end else if (!decide) begin
            wait_r <= wait_r + SET_W'(1);
          end else if (last) begin
            st_r   <= SADC_IDLE;
            done   <= 1'b1;
            result <= kept;
          end else begin
            mask_r   <= mask_r >> 1;
            dac_code <= kept | (mask_r >> 1);
            wait_r   <= '0;
          end
        end
        default: st_r <= SADC_IDLE;
      endcase
    end
  end

  // first trial is the top bit alone
  first_trial_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start && st_r == SADC_IDLE) |=> (dac_code == 8'h80) && run)
    else $error("first trial not at mid scale");

  // a result is only produced after the last bit trial
  done_last_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(done) |-> ($past(mask_r) == 8'h01) && !run)
    else $error("result produced before the last trial");

endmodule : sadc_sar_core

`default_nettype wire

// file: tb/sadc_analog_model.sv
/*
  Analog side of the converter: eight input levels, a one-hot channel switch
  and a comparator that answers dac_code after a short lag.
  Assumes chan_sel is one-hot or zero and levels are static within a conversion.
*/
`timescale 1ns/10ps
`default_nettype none

module sadc_analog_model
  import sadc_pkg::*;
#(
  parameter int LAG_NS = 5
) (
  input  wire logic [NUM_CH*DATA_W-1:0] levels,
  input  wire logic [NUM_CH-1:0]        chan_sel,
  input  wire logic [DATA_W-1:0]        dac_code,
  output logic                          cmp_pin
);
  logic [DATA_W-1:0] sel_level;
  logic              cmp_raw;

  // channel switch, no channel leaves the comparator input at ground
  always_comb begin
    sel_level = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (chan_sel[i]) begin
        sel_level = levels[i*DATA_W +: DATA_W];
      end
    end
  end

  // comparator high when input >= trial code
  assign cmp_raw = (sel_level >= dac_code);
  assign #(LAG_NS) cmp_pin = cmp_raw;
endmodule : sadc_analog_model

`default_nettype wire

// file: tb/sadc_top_tb_top.sv
/*
  Self-checking bench for the converter sequencer: register tasks, software
  start and stop, trigger pin qualification and edges, channel routing, irq.
  Assumes the analog model in the same folder and the package of the design.
*/
`timescale 1ns/10ps
`default_nettype none

module sadc_top_tb_top
  import sadc_pkg::*;
;
  logic                       ref_clk;
  logic                       rst;
  sadc_req_s                  req;
  logic [DATA_W-1:0]          rdata;
  logic                       irq;
  logic                       trig;
  logic                       cmp;
  logic [DATA_W-1:0]          dac;
  logic [NUM_CH-1:0]          chsel;
  logic [NUM_CH*DATA_W-1:0]   lv;
  logic [DATA_W-1:0]          d;
  int                         errors;
  int                         n_checks;
  int                         cyc;
  logic [3:0]                 codes [4];
  logic [7:0]                 onehot [4];

  sadc_top u_sadc_top (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .reg_req              (req),
    .reg_rdata            (rdata),
    .irq                  (irq),
    .external_trigger_pin (trig),
    .cmp_pin              (cmp),
    .dac_code             (dac),
    .chan_sel             (chsel)
  );

  sadc_analog_model u_sadc_analog_model (
    .levels   (lv),
    .chan_sel (chsel),
    .dac_code (dac),
    .cmp_pin  (cmp)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and timeout
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register access and checking
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    req.addr  <= a;
    req.wdata <= v;
    req.wr    <= 1'b1;
    @(posedge ref_clk);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge ref_clk);
    req.rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : idle

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    errors   = 0;
    n_checks = 0;
    cyc      = 0;
    rst      = 1'b1;
    trig     = 1'b0;
    req      = '0;
    lv       = {8'h11, 8'h22, 8'h33, 8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h3C};
    codes    = '{4'h5, 4'h4, 4'h7, 4'h8};
    onehot   = '{8'h02, 8'h01, 8'h08, 8'h10};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    // reset view, reserved start bits, read-only result, unmapped offset
    rd(OFF_START);  chk(d, 8'h7F);
    wr(OFF_START, 8'h00);
    rd(OFF_START);  chk(d, 8'h7F);
    wr(OFF_RESULT, 8'hC3);
    rd(OFF_RESULT); chk(d, 8'h00);
    rd(3'h7);       chk(d, 8'h00);
    chk(chsel, 8'h00);
    wr(OFF_MASK, 8'h01);
    // conversions on four channels with a repeated start mid-way
    for (int k = 0; k < 4; k++) begin
      wr(OFF_MODE, {4'h0, codes[k]});
      idle(1);
      chk(chsel, onehot[k]);
      wr(OFF_START, 8'h80);
      rd(OFF_START);  chk(d, 8'hFF);
      chk(dac, 8'h80);
      idle(6);
      wr(OFF_START, 8'h80);
      idle(25);
      rd(OFF_START);  chk(d, 8'h7F);
      chk({7'h00, irq}, 8'h01);
      rd(OFF_RESULT);
      chk(d, lv[$clog2(onehot[k])*8 +: 8]);
      rd(OFF_STAT);   chk(d, 8'h01);
      idle(1);
      chk({7'h00, irq}, 8'h00);
      rd(OFF_STAT);   chk(d, 8'h00);
    end
    // masked completion sets the flag but no interrupt
    wr(OFF_MASK, 8'h00);
    wr(OFF_MODE, 8'h05);
    wr(OFF_START, 8'h80);
    idle(40);
    chk({7'h00, irq}, 8'h00);
    rd(OFF_STAT);   chk(d, 8'h01);
    // software stop keeps the result and sets no request
    wr(OFF_MASK, 8'h01);
    wr(OFF_MODE, 8'h04);
    wr(OFF_START, 8'h80);
    idle(10);
    wr(OFF_START, 8'h00);
    rd(OFF_START);  chk(d, 8'h7F);
    chk(dac, 8'h00);
    idle(40);
    rd(OFF_RESULT); chk(d, 8'hA5);
    rd(OFF_STAT);   chk(d, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // trigger qualification, rising edge selected
    wr(OFF_MODE, 8'h06);
    wr(OFF_EDGE, 8'h10);
    for (int k = 0; k < 3; k++) begin
      wr(OFF_PMODE, (k != 1) ? 8'h10 : 8'h00);
      wr(OFF_MODE, (k != 0) ? 8'h46 : 8'h06);
      trig <= 1'b0;
      idle(6);
      @(posedge ref_clk) trig <= 1'b1;
      idle(6);
      rd(OFF_START);  chk(d, (k == 2) ? 8'hFF : 8'h7F);
      idle(40);
    end
    rd(OFF_RESULT); chk(d, 8'h5A);
    rd(OFF_STAT);   chk(d, 8'h01);
    // falling edge selected: a rise is ignored, a fall starts
    wr(OFF_EDGE, 8'h00);
    wr(OFF_MODE, 8'h44);
    trig <= 1'b0;
    idle(6);
    rd(OFF_START);  chk(d, 8'hFF);
    idle(40);
    @(posedge ref_clk) trig <= 1'b1;
    idle(6);
    rd(OFF_START);  chk(d, 8'h7F);
    rd(OFF_RESULT); chk(d, 8'h3C);
    test_done();
  end
endmodule : sadc_top_tb_top

`default_nettype wire
